// ### rtl/fhp_host.v
/*
 Host controller that drives a block-erasable parallel flash through its
 chip select, output gate, write strobe, width select, byte-lane address,
 reset/power-down and ready/busy pins, from a simple request port.
 Assumes a 200 MHz clock, a flash pin interface without a clock, and that
 the board resolves the shared data pins from the output enables given.
*/
// Functional notes
// [RULE_01] Byte mode: byte-lane address picks high/low byte.
// [RULE_02] Byte-mode writes present byte-lane address with others.
// [RULE_03] Word mode: byte-lane address pin is unused.
// [RULE_04] Thirteen low address bits select word within block.
// [RULE_05] Five upper address bits select one block.
// [RULE_06] Block bits held through writes, erase, lock.
// [RULE_07] Commands and data go on low byte lane.
// [RULE_08] Low lane returns array, identifier or status data.
// [RULE_09] Lanes float when deselected or outputs disabled.
// [RULE_10] High lane written only in word-mode writes.
// [RULE_11] Chip select held low for every access.
// [RULE_12] Reset pin low aborts and powers down device.
// [RULE_13] Reset pin held low across supply transitions.
// [RULE_14] Wait 430 ns after reset release before access.
// [RULE_15] Reset clears device status to ready.
// [RULE_16] Device comes out of reset in read-array mode.
// [RULE_17] Device drives data only while output gate low.
// [RULE_18] Address and data taken at write strobe rise.
// [RULE_19] Width select low is byte mode, high word mode.
// [RULE_20] Open-drain ready/busy pulls low while busy.
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.vh"
module fhp_host (
    input wire mclk_in,
    input wire nrst_in,
    input wire req_valid_in,
    input wire req_write_in,
    input wire [`FHP_ADDR_W-1:0] req_addr_in,
    input wire req_byte_lane_in,
    input wire [15:0] req_wdata_in,
    input wire word_mode_in,
    input wire power_down_in,
    output wire req_ready_out,
    output reg rsp_valid_out,
    output reg [15:0] rsp_rdata_out,
    output wire flash_ready_out,
    output reg [`FHP_ADDR_W-1:0] addr_out,
    output reg chip_sel_n_out,
    output reg out_gate_n_out,
    output reg write_strobe_n_out,
    output reg width_sel_out,
    output reg reset_powerdown_n_out,
    input wire [7:0] dq_lo_in,
    output reg [7:0] dq_lo_out,
    output reg dq_lo_oe_n_out,
    input wire [6:0] dq_hi_in,
    output reg [6:0] dq_hi_out,
    output reg dq_hi_oe_n_out,
    input wire dq15_in,
    output reg dq15_out,
    output reg dq15_oe_n_out,
    input wire ready_busy_n_in
);
    localparam ST_PDOWN = 6'b00_0001;
    localparam ST_RECOV = 6'b00_0010;
    localparam ST_IDLE = 6'b00_0100;
    localparam ST_WSETUP = 6'b00_1000;
    localparam ST_WSTROBE = 6'b01_0000;
    localparam ST_READ = 6'b10_0000;
    localparam [`FHP_CNT_W-1:0] RECOV_CYC = `FHP_RECOVERY_CYC;

    reg [5:0] state_q;
    reg [`FHP_CNT_W-1:0] cnt_q;
    reg [2:0] rb_sync_q;
    reg rb_level_q;
    reg write_q;
    reg byte_lane_q;
    reg [15:0] wdata_q;
    reg [15:0] dq_s1_q;
    reg [15:0] dq_s2_q;
    reg [15:0] dq_s3_q;
    reg [15:0] rd_data_q;

    // Ready/busy is sampled through three stages and changes once two agree.
    always @(posedge mclk_in) begin
        if (!nrst_in) begin
            // Start at the pull-up level so reset never reports a false busy.
            rb_sync_q <= 3'h7;
            rb_level_q <= 1'b1;
        end else begin
            rb_sync_q <= {rb_sync_q[1:0], ready_busy_n_in};
            if (rb_sync_q[2] == rb_sync_q[1]) begin
                rb_level_q <= rb_sync_q[2];
            end
        end
    end

    // A floating ready/busy pin is read high by the board pull-up.
    assign flash_ready_out = rb_level_q; // RULE_20
    assign req_ready_out = (state_q == ST_IDLE);

    // Data pins are synchronised too; the long gate window absorbs the delay.
    always @(posedge mclk_in) begin
        if (!nrst_in) begin
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
            dq_s3_q <= 16'h0000;
            rd_data_q <= 16'h0000;
        end else begin
            dq_s1_q <= {dq15_in, dq_hi_in, dq_lo_in};
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
            if (dq_s3_q == dq_s2_q) begin
                rd_data_q <= dq_s3_q;
            end
        end
    end

    always @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_q <= ST_PDOWN;
            cnt_q <= {`FHP_CNT_W{1'b0}};
            write_q <= 1'b0;
            byte_lane_q <= 1'b0;
            wdata_q <= 16'h0000;
            addr_out <= {`FHP_ADDR_W{1'b0}};
            chip_sel_n_out <= 1'b1;
            out_gate_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
            width_sel_out <= 1'b0;
            reset_powerdown_n_out <= 1'b0; // RULE_13
            dq_lo_out <= 8'h00;
            dq_lo_oe_n_out <= 1'b1;
            dq_hi_out <= 7'h00;
            dq_hi_oe_n_out <= 1'b1;
            dq15_out <= 1'b0;
            dq15_oe_n_out <= 1'b1;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 16'h0000;
        end else begin
            rsp_valid_out <= 1'b0;
            case (state_q)
                ST_PDOWN: begin
                    // Holding the pin low aborts device work and clears its status.
                    reset_powerdown_n_out <= 1'b0; // RULE_12
                    chip_sel_n_out <= 1'b1;
                    if (!power_down_in) begin
                        reset_powerdown_n_out <= 1'b1;
                        cnt_q <= RECOV_CYC;
                        state_q <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    // No access before the recovery time; device then reads array.
                    if (power_down_in) begin
                        state_q <= ST_PDOWN;
                        reset_powerdown_n_out <= 1'b0;
                    end else if (cnt_q <= 16'h0001) begin // RULE_14
                        state_q <= ST_IDLE; // RULE_16
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_IDLE: begin
                    width_sel_out <= word_mode_in; // RULE_19
                    if (power_down_in) begin
                        reset_powerdown_n_out <= 1'b0; // RULE_15
                        state_q <= ST_PDOWN;
                    end else if (req_valid_in) begin
                        // Word and block selects come straight from the request.
                        addr_out <= req_addr_in; // RULE_04 RULE_05
                        write_q <= req_write_in;
                        byte_lane_q <= req_byte_lane_in;
                        wdata_q <= req_wdata_in;
                        chip_sel_n_out <= 1'b0; // RULE_11
                        if (req_write_in) begin
                            dq_lo_out <= req_wdata_in[7:0]; // RULE_07
                            dq_lo_oe_n_out <= 1'b0;
                            dq_hi_out <= req_wdata_in[14:8];
                            dq_hi_oe_n_out <= ~word_mode_in; // RULE_10
                            // In byte mode the top pin carries the byte-lane address.
                            dq15_out <= word_mode_in ? req_wdata_in[15] : req_byte_lane_in; // RULE_02
                            dq15_oe_n_out <= 1'b0;
                            cnt_q <= `FHP_SETUP_CYC;
                            state_q <= ST_WSETUP;
                        end else begin
                            dq15_out <= req_byte_lane_in; // RULE_01
                            dq15_oe_n_out <= word_mode_in; // RULE_03
                            out_gate_n_out <= 1'b0; // RULE_17
                            cnt_q <= `FHP_READ_CYC;
                            state_q <= ST_READ;
                        end
                    end
                end
                ST_WSETUP: begin
                    if (cnt_q <= 16'h0001) begin
                        write_strobe_n_out <= 1'b0;
                        cnt_q <= `FHP_STROBE_CYC;
                        state_q <= ST_WSTROBE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_WSTROBE: begin
                    if (cnt_q <= 16'h0001) begin
                        // Address, block select and data stay put across the rising edge.
                        write_strobe_n_out <= 1'b1; // RULE_18 RULE_06
                        cnt_q <= `FHP_SETUP_CYC;
                        state_q <= ST_READ;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                ST_READ: begin
                    // Shared with write hold; reads sample just before gate release.
                    if (cnt_q <= 16'h0001) begin
                        if (!write_q) begin
                            rsp_valid_out <= 1'b1;
                            if (!width_sel_out) begin
                                rsp_rdata_out <= {8'h00, rd_data_q[7:0]}; // RULE_08
                            end else begin
                                rsp_rdata_out <= rd_data_q;
                            end
                        end
                        out_gate_n_out <= 1'b1; // RULE_09
                        chip_sel_n_out <= 1'b1;
                        dq_lo_oe_n_out <= 1'b1;
                        dq_hi_oe_n_out <= 1'b1;
                        dq15_oe_n_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_PDOWN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### include/fhp_defs.vh
/*
 Constants for the flash host port controller: pin field layout and
 timing counts at a 200 MHz controller clock.
 Assumes the including file works in whole clock cycles of 5 ns.
*/
`ifndef FHP_DEFS_VH
`define FHP_DEFS_VH
`define FHP_CLK_PERIOD_PS 5000
`define FHP_WORD_ADDR_W 13
`define FHP_BLOCK_ADDR_W 5
`define FHP_ADDR_W 18
`define FHP_BLOCK_LSB 13
`define FHP_RECOVERY_NS 430
`define FHP_RECOVERY_CYC ((`FHP_RECOVERY_NS * 1000 + `FHP_CLK_PERIOD_PS - 1) / `FHP_CLK_PERIOD_PS)
`define FHP_STROBE_CYC 16'h0010
`define FHP_SETUP_CYC 16'h0004
`define FHP_READ_CYC 16'h0012
`define FHP_CNT_W 16
`endif

// ### tb/fhp_host_chk.sv
/* Pin checker for the flash host controller.
 Assumes binding onto fhp_host with one 200 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "fhp_defs.vh"
module fhp_chk (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic power_down_in,
    input wire logic req_ready_out,
    input wire logic chip_sel_n_out,
    input wire logic out_gate_n_out,
    input wire logic write_strobe_n_out,
    input wire logic width_sel_out,
    input wire logic reset_powerdown_n_out,
    input wire logic dq_lo_oe_n_out,
    input wire logic dq_hi_oe_n_out,
    input wire logic [17:0] addr_out,
    input wire logic [7:0] dq_lo_out
);
    localparam int RECOVERY = `FHP_RECOVERY_CYC;
    logic [7:0] rec_q;
    always @(posedge mclk_in) begin
        if (!nrst_in || !reset_powerdown_n_out) rec_q <= 8'h00;
        else if (rec_q != 8'hff) rec_q <= rec_q + 8'h01;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    sequence strobe_held;
        !write_strobe_n_out && $stable(addr_out) && $stable(dq_lo_out);
    endsequence
    recovery_wait_a: assert property (!chip_sel_n_out |-> rec_q >= RECOVERY)
        else $error("access before recovery");
    strobe_select_a: assert property (!write_strobe_n_out |-> !chip_sel_n_out)
        else $error("strobe without select");
    gate_select_a: assert property (!out_gate_n_out |-> !chip_sel_n_out)
        else $error("gate without select");
    strobe_pulse_a: assert property ($fell(write_strobe_n_out) |->
        strobe_held[*8] ##1 strobe_held[*8] ##1 write_strobe_n_out) else $error("bad strobe");
    cmd_lane_a: assert property (!write_strobe_n_out |-> !dq_lo_oe_n_out)
        else $error("low lane idle in write");
    high_lane_a: assert property (!write_strobe_n_out |-> dq_hi_oe_n_out == !width_sel_out)
        else $error("high lane wrong for width");
    no_fight_a: assert property (!out_gate_n_out |-> dq_lo_oe_n_out && dq_hi_oe_n_out)
        else $error("host drives during read");
    pd_entry_a: assert property (power_down_in && req_ready_out |->
        ##[1:4] !reset_powerdown_n_out) else $error("power-down not entered");
endmodule
bind fhp_host fhp_chk chk_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .power_down_in(power_down_in),
    .req_ready_out(req_ready_out), .chip_sel_n_out(chip_sel_n_out),
    .out_gate_n_out(out_gate_n_out), .write_strobe_n_out(write_strobe_n_out),
    .width_sel_out(width_sel_out), .reset_powerdown_n_out(reset_powerdown_n_out),
    .dq_lo_oe_n_out(dq_lo_oe_n_out), .dq_hi_oe_n_out(dq_hi_oe_n_out), .addr_out(addr_out),
    .dq_lo_out(dq_lo_out));
`default_nettype wire

// ### tb/fhp_flash_model.sv
/* Flash device model: raw array on x8/x16 pins, busy after writes.
 Assumes the host pins of fhp_host; ready/busy has a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module fhp_flash_model (
    input wire logic [17:0] addr_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic width_in,
    input wire logic reset_powerdown_n_in,
    input wire logic [15:0] dq_in,
    input wire logic [2:0] dq_oe_n_in,
    output logic [15:0] dq_out,
    output logic rb_n_out = 1'b1
);
    logic [15:0] mem [int];
    logic [15:0] w, dev;
    logic [2:0] den;
    always_comb begin
        w = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
        dev = width_in ? w : {8'h00, dq_in[15] ? w[15:8] : w[7:0]};
        den = (!ce_n_in && !oe_n_in && reset_powerdown_n_in) ?
            {!width_in, !width_in, 1'b0} : 3'b111;
        for (int i = 0; i < 16; i++) begin
            // Released lines show the inverse so a stale value never reads as good.
            dq_out[i] = !dq_oe_n_in[i/8 + i/15] ? dq_in[i] : !den[i/8 + i/15] ? dev[i] : ~dq_in[i];
        end
    end
    always @(posedge we_n_in or negedge reset_powerdown_n_in) begin
        if (!reset_powerdown_n_in) begin
            rb_n_out <= 1'b1;
        end else if (!ce_n_in) begin
            if (width_in) mem[addr_in] = dq_out;
            else if (dq_out[15]) mem[addr_in] = {dq_out[7:0], w[7:0]};
            else mem[addr_in] = {w[15:8], dq_out[7:0]};
            rb_n_out <= 1'b0;
            rb_n_out <= #200 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### tb/flash_host_port_and_reset_tb_top.sv
/* Self-checking bench: flash host controller against a flash model.
 Assumes fhp_host, fhp_flash_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module flash_host_port_and_reset_tb_top;
    logic mclk_in = 1'b0, nrst_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
    logic req_byte_lane_in = 1'b0, word_mode_in = 1'b1, power_down_in = 1'b0;
    logic [17:0] req_addr_in = 18'h0_0000;
    logic [15:0] req_wdata_in = 16'h0000;
    wire req_ready_out, rsp_valid_out, flash_ready_out, chip_sel_n_out, out_gate_n_out;
    wire write_strobe_n_out, width_sel_out, reset_powerdown_n_out, dq_lo_oe_n_out;
    wire dq_hi_oe_n_out, dq15_out, dq15_oe_n_out, ready_busy_n_in, dq15_in;
    wire [15:0] rsp_rdata_out, dq_bus;
    wire [17:0] addr_out;
    wire [7:0] dq_lo_out, dq_lo_in;
    wire [6:0] dq_hi_out, dq_hi_in;
    int n_errors = 0, checks = 0;
    logic [15:0] ref_mem [int];
    assign {dq15_in, dq_hi_in, dq_lo_in} = dq_bus;
    fhp_host dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_byte_lane_in(req_byte_lane_in), .req_wdata_in(req_wdata_in),
        .word_mode_in(word_mode_in), .power_down_in(power_down_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .flash_ready_out(flash_ready_out),
        .addr_out(addr_out), .chip_sel_n_out(chip_sel_n_out), .out_gate_n_out(out_gate_n_out),
        .write_strobe_n_out(write_strobe_n_out), .width_sel_out(width_sel_out),
        .reset_powerdown_n_out(reset_powerdown_n_out), .dq_lo_in(dq_lo_in),
        .dq_lo_out(dq_lo_out), .dq_lo_oe_n_out(dq_lo_oe_n_out), .dq_hi_in(dq_hi_in),
        .dq_hi_out(dq_hi_out), .dq_hi_oe_n_out(dq_hi_oe_n_out), .dq15_in(dq15_in),
        .dq15_out(dq15_out), .dq15_oe_n_out(dq15_oe_n_out), .ready_busy_n_in(ready_busy_n_in));
    fhp_flash_model flash_u (.addr_in(addr_out), .ce_n_in(chip_sel_n_out),
        .oe_n_in(out_gate_n_out), .we_n_in(write_strobe_n_out), .width_in(width_sel_out),
        .reset_powerdown_n_in(reset_powerdown_n_out),
        .dq_in({dq15_out, dq_hi_out, dq_lo_out}),
        .dq_oe_n_in({dq15_oe_n_out, dq_hi_oe_n_out, dq_lo_oe_n_out}), .dq_out(dq_bus),
        .rb_n_out(ready_busy_n_in));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [17:0] a, input logic l,
        input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        req_valid_in <= 1'b1;
        req_write_in <= wr;
        req_addr_in <= a;
        req_byte_lane_in <= l;
        req_wdata_in <= d;
        do @(posedge mclk_in); while (req_ready_out !== 1'b1 && ++n < 300);
        req_valid_in <= 1'b0;
        do @(posedge mclk_in); while ((wr ? req_ready_out : rsp_valid_out) !== 1'b1 && ++n < 600);
        q = rsp_rdata_out;
        if (n >= 600) n_errors++;
    endtask
    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial forever #2.5 mclk_in = ~mclk_in;
    initial begin
        #60us;
        n_errors++;
        finish_test();
    end
    initial begin
        int seed;
        logic [15:0] q, d, w, e;
        logic [17:0] a;
        logic l;
        seed = 32'h4480_4276;
        repeat (3) @(posedge mclk_in);
        nrst_in <= 1'b1;
        for (int m = 1; m >= 0; m--) begin
            word_mode_in <= m[0];
            @(posedge mclk_in);
            for (int i = 0; i < 8; i++) begin
                a = (i == 0) ? 18'h0_0000 : (i == 1) ? 18'h3_ffff : 18'($random(seed));
                d = 16'($random(seed));
                l = 1'($random(seed));
                w = ref_mem.exists(a) ? ref_mem[a] : 16'hffff;
                if (m == 1) w = d;
                else if (l) w[15:8] = d[7:0];
                else w[7:0] = d[7:0];
                ref_mem[a] = w;
                e = (m == 1) ? w : {8'h00, l ? w[15:8] : w[7:0]};
                xfer(1'b1, a, l, d, q);
                check("busy_seen", 16'h0000, {15'h0000, flash_ready_out});
                xfer(1'b0, a, l, 16'h0000, q);
                check("read_data", e, q);
            end
        end
        power_down_in <= 1'b1;
        repeat (60) @(posedge mclk_in);
        check("pd_pin", 16'h0000, {15'h0000, reset_powerdown_n_out});
        check("rb_float", 16'h0001, {15'h0000, flash_ready_out});
        power_down_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        check("pd_release", 16'h0001, {15'h0000, reset_powerdown_n_out});
        power_down_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        check("pd_abort", 16'h0000, {15'h0000, reset_powerdown_n_out});
        power_down_in <= 1'b0;
        xfer(1'b0, a, l, 16'h0000, q);
        check("read_after_pd", e, q);
        finish_test();
    end
endmodule
`default_nettype wire
